// ---- design/scfe_top.sv ----
// serial command front end: apb registers, dual serial link, station filter, setup store
//
// Operation
// - after reset without restore, link runs 9600 baud, 8 data bits, no parity
// - baud divisor accepts rates up to and including 115200 baud on both links
// - parity even/odd/none, 7 or 8 data bits, 1 or 2 stop bits selectable
// - station filter defaults off; station number 0 to 15, default 4
// - with filter on, only prefixed messages for this station are passed from the rs485 link
// - prefix is start-of-text then station number; host sends it each command
// - characters from the rs232 link are never filtered
// - rs485 link runs one-to-one or multidrop, chosen by the filter switch
// - setup freeze (default off) rejects configuration changes
// - while frozen, setup values read as zero; only a restore can change them
// - id string and setup can be saved to and restored from nonvolatile store
// - port and polarity values 0 to 255, byte number 0 to 5; strobe only 0 or 1
// - bit set and bit clear change one output bit of one byte
// - replies go out on the link the last command came in on
`timescale 1ns/1ps

module scfe_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);
  localparam logic [PW-1:0] LAST = PW'(D - 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } scfe_fifo_st_t;

  scfe_fifo_st_t q, d;
  logic          push, pop;

  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    if (push & ~pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop & ~push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

module scfe_top import scfe_pkg::*; #(
  parameter logic [15:0] BAUD_DIV_RESET = 16'(DIV_DEFAULT)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rs232_rxd,
  output logic             rs232_txd,
  input  wire logic        rs485_rxd,
  output logic             rs485_txd,
  output logic             rs485_de_n,
  output logic      [47:0] dout,
  output logic             strobe,
  input  wire logic        nv_ld_valid,
  input  wire logic [6:0]  nv_ld_addr,
  input  wire logic [31:0] nv_ld_data,
  output logic             nv_wr_valid,
  output logic      [6:0]  nv_wr_addr,
  output logic      [31:0] nv_wr_data
);
  typedef struct packed {
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic [15:0]               div;
    logic [1:0]                par;
    logic                      bits7;
    logic                      stop2;
    logic [3:0]                stn;
    logic                      net_en;
    logic                      lock;
    logic [ID_MAX-1:0][7:0]    id;
    logic [6:0]                id_ptr;
    logic                      ovr;
    logic                      cmd_err;
    logic                      id_trunc;
    logic                      frm_err;
    logic                      par_err;
    logic [2:0]                s232;
    logic [2:0]                s485;
    logic                      f232;
    logic                      f485;
    scfe_rx_t                  rx_st;
    logic [15:0]               rx_cnt;
    logic [3:0]                rx_bit;
    logic [7:0]                rx_sh;
    logic                      rx_if;
    logic                      rx_par;
    scfe_flt_t                 flt;
    logic                      pend_v;
    logic [7:0]                pend;
    scfe_tx_t                  tx_st;
    logic [15:0]               tx_cnt;
    logic [3:0]                tx_bit;
    logic [7:0]                tx_sh;
    logic                      tx_if;
    logic                      tx_par;
    logic                      txd232;
    logic                      txd485;
    logic                      de_n;
    logic                      sv_busy;
    logic [6:0]                sv_addr;
    logic                      nv_wr;
    logic [6:0]                nv_addr;
    logic [31:0]               nv_data;
    logic [NUM_BYTES-1:0][7:0] latch;
    logic [NUM_BYTES-1:0][7:0] pol;
    logic [NUM_BYTES-1:0][7:0] dout;
    logic                      strobe;
  } scfe_st_t;

  scfe_st_t   q, d;
  logic       fifo_ready, fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  logic       acc, done, line, rx_tick, tx_tick, accept;
  logic [7:0] ch;

  // byte commands: value in [7:0], set flag in bit 8, byte number in [19:16], nothing else set
  function automatic logic byte_cmd_ok(input logic [31:0] w);
    byte_cmd_ok = (w[15:9] == '0) && (w[31:20] == '0) && (w[19:16] <= LAST_BYTE);
  endfunction

  function automatic logic [3:0] last_bit(input logic bits7);
    last_bit = bits7 ? 4'h6 : 4'h7;
  endfunction

  function automatic logic tx_level(input scfe_st_t s);
    case (s.tx_st)
      TX_START: tx_level = 1'b0;
      TX_DATA:  tx_level = s.tx_sh[0];
      TX_PAR:   tx_level = s.tx_par ^ (s.par == PAR_ODD);
      default:  tx_level = 1'b1;
    endcase
  endfunction

  assign acc      = psel & penable;
  assign done     = acc & q.pready;
  // pop only what the answer already showed as valid
  assign fifo_pop = done & ~pwrite & (paddr == A_RXDATA) & q.prdata[8];
  assign line     = q.rx_if ? q.f485 : q.f232;
  assign rx_tick  = (q.rx_cnt == '0);
  assign tx_tick  = (q.tx_cnt == '0);
  assign ch       = q.bits7 ? {1'b0, q.rx_sh[7:1]} : q.rx_sh;

  scfe_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (q.pend_v),
    .in_ready  (fifo_ready),
    .in_data   (q.pend),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_comb begin
    d         = q;
    accept    = 1'b0;
    d.pready  = acc & ~q.pready;
    d.pslverr = 1'b0;
    d.nv_wr   = 1'b0;

    // restore from nonvolatile store, bypasses the freeze
    if (nv_ld_valid) begin
      if (nv_ld_addr == NV_CFG_ADDR) begin
        d.div    = nv_ld_data[15:0];
        d.par    = nv_ld_data[CFG_PAR_LO +: 2];
        d.bits7  = nv_ld_data[CFG_BITS7];
        d.stop2  = nv_ld_data[CFG_STOP2];
        d.stn    = nv_ld_data[CFG_STN_LO +: 4];
        d.net_en = nv_ld_data[CFG_NET];
        d.lock   = nv_ld_data[CFG_LOCK];
      end else if (nv_ld_addr < ID_MAX_IDX) begin
        d.id[nv_ld_addr] = nv_ld_data[7:0];
      end
    end

    if (acc & ~q.pready) begin
      d.prdata = '0;
      case (paddr)
        A_CTRL:   d.prdata = {30'h0, q.sv_busy, q.lock};
        A_DIV:    d.prdata = q.lock ? '0 : {16'h0, q.div};
        A_FRAME:  d.prdata = q.lock ? '0 : {28'h0, q.stop2, q.bits7, q.par};
        A_NET:    d.prdata = q.lock ? '0 : {23'h0, q.net_en, 4'h0, q.stn};
        A_STATUS: d.prdata = {23'h0, q.par_err, q.frm_err, q.sv_busy, q.id_trunc, q.cmd_err,
                              q.ovr, q.rx_if, (q.tx_st != TX_IDLE), fifo_valid};
        A_RXDATA: d.prdata = {23'h0, fifo_valid, fifo_data};
        A_IDIDX:  d.prdata = {25'h0, q.id_ptr};
        A_IDDATA: d.prdata = (q.lock || q.id_ptr >= ID_MAX_IDX) ? '0 : {24'h0, q.id[q.id_ptr]};
        A_TXDATA, A_PORTWR, A_POLWR, A_BITCMD: d.prdata = '0;
        A_STROBE: d.prdata = {31'h0, q.strobe};
        default:  d.pslverr = 1'b1;
      endcase
    end

    if (done & pwrite & ~q.pslverr) begin
      case (paddr)
        A_CTRL: begin
          d.lock = pwdata[CTRL_LOCK];
          if (pwdata[CTRL_SAVE] & ~q.sv_busy) begin
            d.sv_busy = 1'b1;
            d.sv_addr = '0;
          end
        end
        A_DIV: begin
          if (q.lock || pwdata[15:0] < DIV_MIN || pwdata[31:16] != '0) begin
            d.cmd_err = 1'b1;
          end else begin
            d.div = pwdata[15:0];
          end
        end
        A_FRAME: begin
          if (q.lock || pwdata[1:0] == 2'h3 || pwdata[31:4] != '0) begin
            d.cmd_err = 1'b1;
          end else begin
            d.par   = pwdata[1:0];
            d.bits7 = pwdata[FRM_BITS7];
            d.stop2 = pwdata[FRM_STOP2];
          end
        end
        A_NET: begin
          if (q.lock || pwdata[7:4] != '0 || pwdata[31:9] != '0) begin
            d.cmd_err = 1'b1;
          end else begin
            d.stn    = pwdata[3:0];
            d.net_en = pwdata[NET_EN];
          end
        end
        A_STATUS: begin
          d.ovr      = q.ovr & ~pwdata[ST_OVR];
          d.cmd_err  = q.cmd_err & ~pwdata[ST_CMDERR];
          d.id_trunc = q.id_trunc & ~pwdata[ST_IDTRUNC];
          d.frm_err  = q.frm_err & ~pwdata[ST_FRMERR];
          d.par_err  = q.par_err & ~pwdata[ST_PARERR];
        end
        A_TXDATA: begin
          if (q.tx_st != TX_IDLE) begin
            d.cmd_err = 1'b1;
          end else begin
            d.tx_sh  = pwdata[7:0];
            d.tx_if  = q.rx_if;
            d.tx_par = 1'b0;
            d.tx_cnt = q.div - 1'b1;
            d.tx_st  = TX_START;
          end
        end
        A_IDIDX: d.id_ptr = pwdata[6:0];
        A_IDDATA: begin
          if (q.lock) begin
            d.cmd_err = 1'b1;
          end else if (q.id_ptr >= ID_MAX_IDX) begin
            d.id_trunc = 1'b1;
          end else begin
            d.id[q.id_ptr] = pwdata[7:0];
            d.id_ptr       = q.id_ptr + 1'b1;
          end
        end
        A_PORTWR, A_POLWR: begin
          if (!byte_cmd_ok(pwdata) || pwdata[CMD_SET]) begin
            d.cmd_err = 1'b1;
          end else if (paddr == A_PORTWR) begin
            d.latch[pwdata[CMD_BYTE_LO +: 3]] = pwdata[7:0];
          end else begin
            d.pol[pwdata[CMD_BYTE_LO +: 3]] = pwdata[7:0];
          end
        end
        A_BITCMD: begin
          if (!byte_cmd_ok(pwdata) || pwdata[7:3] != '0) begin
            d.cmd_err = 1'b1;
          end else begin
            d.latch[pwdata[CMD_BYTE_LO +: 3]][pwdata[2:0]] = pwdata[CMD_SET];
          end
        end
        A_STROBE: begin
          if (pwdata[31:1] != '0) begin
            d.cmd_err = 1'b1;
          end else begin
            d.strobe = pwdata[0];
          end
        end
        default: d.cmd_err = q.cmd_err;
      endcase
    end

    // save walk: id bytes at 0..71, setup word last
    if (q.sv_busy) begin
      d.nv_wr   = 1'b1;
      d.nv_addr = q.sv_addr;
      if (q.sv_addr == NV_CFG_ADDR) begin
        d.nv_data = {6'h0, q.lock, q.net_en, q.stn, q.stop2, q.bits7, q.par, q.div};
        d.sv_busy = 1'b0;
      end else begin
        d.nv_data = {24'h0, q.id[q.sv_addr]};
        d.sv_addr = q.sv_addr + 1'b1;
      end
    end

    // pin inputs: three stages, level taken once stages two and three agree
    d.s232 = {q.s232[1:0], rs232_rxd};
    d.s485 = {q.s485[1:0], rs485_rxd};
    if (q.s232[2] == q.s232[1]) begin
      d.f232 = q.s232[1];
    end
    if (q.s485[2] == q.s485[1]) begin
      d.f485 = q.s485[1];
    end

    if (q.pend_v & fifo_ready) begin
      d.pend_v = 1'b0;
    end

    if (q.rx_st != RX_IDLE) begin
      d.rx_cnt = rx_tick ? q.div - 1'b1 : q.rx_cnt - 1'b1;
    end
    case (q.rx_st)
      RX_IDLE: begin
        d.rx_cnt = {1'b0, q.div[15:1]};
        if (!q.f232) begin
          d.rx_if = 1'b0;
          d.rx_st = RX_START;
        end else if (!q.f485 && !(q.tx_if && q.tx_st != TX_IDLE)) begin
          // half duplex: own transmission is not heard as a command
          d.rx_if = 1'b1;
          d.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          d.rx_st  = line ? RX_IDLE : RX_DATA;
          d.rx_bit = '0;
          d.rx_par = 1'b0;
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          d.rx_sh  = {line, q.rx_sh[7:1]};
          d.rx_par = q.rx_par ^ line;
          d.rx_bit = q.rx_bit + 1'b1;
          if (q.rx_bit == last_bit(q.bits7)) begin
            d.rx_st = (q.par == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (rx_tick) begin
          if ((q.rx_par ^ line) != (q.par == PAR_ODD)) begin
            d.par_err = 1'b1;
          end
          d.rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          d.rx_st = RX_IDLE;
          if (!line) begin
            d.frm_err = 1'b1;
          end else if (!(q.rx_if && q.net_en)) begin
            accept = 1'b1;
          end else if (ch == CH_STX) begin
            d.flt = F_ADDR;
          end else begin
            case (q.flt)
              F_ADDR:  d.flt = (ch == {4'h0, q.stn}) ? F_PASS : F_WAIT;
              F_PASS: begin
                accept = 1'b1;
                if (ch == CH_LF) begin
                  d.flt = F_WAIT;
                end
              end
              default: d.flt = F_WAIT;
            endcase
          end
        end
      end
      default: d.rx_st = RX_IDLE;
    endcase

    // no stall possible on a serial line; a char lost to a full path is flagged
    if (accept) begin
      if (q.pend_v & ~fifo_ready) begin
        d.ovr = 1'b1;
      end else begin
        d.pend_v = 1'b1;
        d.pend   = ch;
      end
    end

    // frame settings are read live; change them only while the link is idle
    if (q.tx_st != TX_IDLE) begin
      d.tx_cnt = tx_tick ? q.div - 1'b1 : q.tx_cnt - 1'b1;
    end
    case (q.tx_st)
      TX_IDLE: d.tx_bit = '0;
      TX_START: begin
        if (tx_tick) begin
          d.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          d.tx_par = q.tx_par ^ q.tx_sh[0];
          d.tx_sh  = {1'b1, q.tx_sh[7:1]};
          d.tx_bit = q.tx_bit + 1'b1;
          if (q.tx_bit == last_bit(q.bits7)) begin
            d.tx_bit = '0;
            d.tx_st  = (q.par == PAR_NONE) ? TX_STOP : TX_PAR;
          end
        end
      end
      TX_PAR: begin
        if (tx_tick) begin
          d.tx_st = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          if (q.tx_bit == {3'h0, q.stop2}) begin
            d.tx_st = TX_IDLE;
          end else begin
            d.tx_bit = q.tx_bit + 1'b1;
          end
        end
      end
      default: d.tx_st = TX_IDLE;
    endcase

    d.txd232 = (d.tx_st != TX_IDLE && !d.tx_if) ? tx_level(d) : 1'b1;
    d.txd485 = (d.tx_st != TX_IDLE && d.tx_if) ? tx_level(d) : 1'b1;
    d.de_n   = ~(d.tx_st != TX_IDLE && d.tx_if);

    for (int i = 0; i < NUM_BYTES; i++) begin
      d.dout[i] = d.latch[i] ^ d.pol[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q        <= '0;
      q.div    <= BAUD_DIV_RESET;
      q.par    <= PAR_NONE;
      q.stn    <= STATION_RESET;
      q.s232   <= 3'h7;
      q.s485   <= 3'h7;
      q.f232   <= 1'b1;
      q.f485   <= 1'b1;
      q.txd232 <= 1'b1;
      q.txd485 <= 1'b1;
      q.de_n   <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign rs232_txd   = q.txd232;
  assign rs485_txd   = q.txd485;
  assign rs485_de_n  = q.de_n;
  assign dout        = q.dout;
  assign strobe      = q.strobe;
  assign nv_wr_valid = q.nv_wr;
  assign nv_wr_addr  = q.nv_addr;
  assign nv_wr_data  = q.nv_data;
endmodule

// ---- design/scfe_pkg.sv ----
// constants, register map and state types of the serial command front end
package scfe_pkg;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          BAUD_DEFAULT = 9600;
  localparam int          BAUD_MAX     = 115_200;
  localparam int          DIV_DEFAULT  = CLK_HZ / BAUD_DEFAULT;
  localparam logic [15:0] DIV_MIN      = 16'(CLK_HZ / BAUD_MAX);
  localparam int          ID_MAX       = 72;
  localparam logic [6:0]  ID_MAX_IDX   = 7'(ID_MAX);
  localparam logic [6:0]  NV_CFG_ADDR  = 7'(ID_MAX);
  localparam int          NUM_BYTES    = 6;
  localparam logic [3:0]  LAST_BYTE    = 4'(NUM_BYTES - 1);
  localparam int          FIFO_W       = 8;
  localparam int          FIFO_D       = 4;

  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_DIV     = 8'h04;
  localparam logic [7:0] A_FRAME   = 8'h08;
  localparam logic [7:0] A_NET     = 8'h0C;
  localparam logic [7:0] A_STATUS  = 8'h10;
  localparam logic [7:0] A_RXDATA  = 8'h14;
  localparam logic [7:0] A_TXDATA  = 8'h18;
  localparam logic [7:0] A_IDIDX   = 8'h1C;
  localparam logic [7:0] A_IDDATA  = 8'h20;
  localparam logic [7:0] A_PORTWR  = 8'h24;
  localparam logic [7:0] A_POLWR   = 8'h28;
  localparam logic [7:0] A_BITCMD  = 8'h2C;
  localparam logic [7:0] A_STROBE  = 8'h30;

  localparam int CTRL_LOCK   = 0;
  localparam int CTRL_SAVE   = 1;
  localparam int FRM_BITS7   = 2;
  localparam int FRM_STOP2   = 3;
  localparam int NET_EN      = 8;
  localparam int CMD_SET     = 8;
  localparam int CMD_BYTE_LO = 16;
  localparam int CFG_PAR_LO  = 16;
  localparam int CFG_BITS7   = 18;
  localparam int CFG_STOP2   = 19;
  localparam int CFG_STN_LO  = 20;
  localparam int CFG_NET     = 24;
  localparam int CFG_LOCK    = 25;
  localparam int ST_RXAV     = 0;
  localparam int ST_TXBUSY   = 1;
  localparam int ST_IF485    = 2;
  localparam int ST_OVR      = 3;
  localparam int ST_CMDERR   = 4;
  localparam int ST_IDTRUNC  = 5;
  localparam int ST_SAVEBUSY = 6;
  localparam int ST_FRMERR   = 7;
  localparam int ST_PARERR   = 8;

  localparam logic [1:0] PAR_NONE      = 2'h0;
  localparam logic [1:0] PAR_EVEN      = 2'h1;
  localparam logic [1:0] PAR_ODD       = 2'h2;
  localparam logic [3:0] STATION_RESET = 4'h4;
  localparam logic [7:0] CH_STX        = 8'h02;
  localparam logic [7:0] CH_LF         = 8'h0A;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } scfe_rx_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } scfe_tx_t;

  typedef enum logic [1:0] {
    F_WAIT = 2'b00,
    F_ADDR = 2'b01,
    F_PASS = 2'b10
  } scfe_flt_t;
endpackage

// ---- dv/scfe_checker.sv ----
// port assertions of the front end
`timescale 1ns/1ps
module scfe_checker import scfe_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rs485_txd,
  input wire logic        rs485_de_n,
  input wire logic [47:0] dout,
  input wire logic        strobe,
  input wire logic        nv_wr_valid,
  input wire logic [6:0]  nv_wr_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lat; psel && penable && !$past(penable) |=> pready; endproperty
  a_lat: assert property (p_lat) else $error("bad wait state");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_err; pready && paddr > A_STROBE |-> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("no pslverr");
  property p_idle; rs485_de_n |-> rs485_txd; endproperty
  a_idle: assert property (p_idle) else $error("485 idle");
  property p_stb; $changed(strobe) |-> $past(pready && pwrite && paddr == A_STROBE); endproperty
  a_stb: assert property (p_stb) else $error("strobe");
  property p_out; $changed(dout) |-> $past(pready && pwrite); endproperty
  a_out: assert property (p_out) else $error("dout");
  property p_bit; $changed(dout) && $past(paddr == A_BITCMD) |-> $onehot(dout ^ $past(dout)); endproperty
  a_bit: assert property (p_bit) else $error("multi bit");
  property p_nv0; $rose(nv_wr_valid) |-> nv_wr_addr == 7'h00; endproperty
  a_nv0: assert property (p_nv0) else $error("save start");
  property p_nvs;
    nv_wr_valid && nv_wr_addr < NV_CFG_ADDR |=> nv_wr_valid && nv_wr_addr == $past(nv_wr_addr) + 7'h01;
  endproperty
  a_nvs: assert property (p_nvs) else $error("save step");
  property p_nve; nv_wr_valid && nv_wr_addr == NV_CFG_ADDR |=> !nv_wr_valid; endproperty
  a_nve: assert property (p_nve) else $error("save end");
  c_err: cover property (pready && pslverr);
  c_tx: cover property ($fell(rs485_de_n));
  c_nv: cover property (nv_wr_valid && nv_wr_addr == NV_CFG_ADDR);
endmodule
bind scfe_top scfe_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rs485_txd(rs485_txd), .rs485_de_n(rs485_de_n), .dout(dout), .strobe(strobe),
  .nv_wr_valid(nv_wr_valid), .nv_wr_addr(nv_wr_addr));

// ---- dv/scfe_host.sv ----
// host model sending framed characters on either receive pin
`timescale 1ns/1ps
module scfe_host import scfe_pkg::*; #(
  parameter logic [15:0] DIV = 16'h0010
) (
  input  wire logic pclk,
  output logic      rs232_rxd,
  output logic      rs485_rxd
);
  initial begin
    rs232_rxd = 1'b1;
    rs485_rxd = 1'b1; // bias network holds mark while undriven
  end
  task automatic send(input logic l, input logic [7:0] c, input logic b7, input logic [1:0] par);
    logic [11:0] f;
    int nb;
    f = {3'h7, c, 1'b0};
    if (b7) f[8] = 1'b1;
    if (par != PAR_NONE) f[b7 ? 8 : 9] = ^(c & (b7 ? 8'h7F : 8'hFF)) ^ (par == PAR_ODD);
    nb = (b7 ? 9 : 10) + int'(par != PAR_NONE);
    for (int i = 0; i < nb; i++) begin
      @(posedge pclk);
      if (l) rs485_rxd <= f[i];
      else rs232_rxd <= f[i];
      repeat (DIV - 1) @(posedge pclk);
    end
  endtask
endmodule

// ---- dv/scfe_top_test.sv ----
// self-checking bench of the serial command front end
`timescale 1ns/1ps
module scfe_top_test import scfe_pkg::*; ;
  localparam logic [15:0] DIV = 16'h0010;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, nld, nwd;
  logic        r232, r485, t232, t485, de_n, strobe, nlv, nwv;
  logic [6:0]  nla, nwa;
  logic [47:0] dout;
  int          fail_count, total_checks;
  scfe_top #(.BAUD_DIV_RESET(DIV)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rs232_rxd(r232), .rs232_txd(t232), .rs485_rxd(r485), .rs485_txd(t485),
    .rs485_de_n(de_n), .dout(dout), .strobe(strobe), .nv_ld_valid(nlv), .nv_ld_addr(nla),
    .nv_ld_data(nld), .nv_wr_valid(nwv), .nv_wr_addr(nwa), .nv_wr_data(nwd));
  scfe_host #(.DIV(DIV)) u_host (.pclk(pclk), .rs232_rxd(r232), .rs485_rxd(r485));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    chk(32'(n < 20), 32'h1);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // let outputs settle after the write
  task automatic wrs(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask
  task automatic rxe(input logic [31:0] e);
    repeat (8) @(posedge pclk);
    rd(A_RXDATA);
    chk(rdat, e);
  endtask
  task automatic t_reset();
    rd(A_DIV); chk(rdat, {16'h0, DIV});
    rd(A_FRAME); chk(rdat, 32'h0);
    rd(A_NET); chk(rdat, 32'h4);
    rd(A_CTRL); chk(rdat, 32'h0);
    rd(8'h40); chk(rerr, 1);
  endtask
  task automatic t_frame();
    u_host.send(0, 8'h43, 0, PAR_NONE); rxe(32'h143);
    bus(1, A_FRAME, 32'h5); u_host.send(0, 8'h35, 1, PAR_EVEN); rxe(32'h135);
    bus(1, A_FRAME, 32'hA); u_host.send(0, 8'hC3, 0, PAR_ODD); rxe(32'h1C3);
    rd(A_STATUS); chk(rdat[ST_PARERR], 0);
    bus(1, A_FRAME, 32'h0);
  endtask
  task automatic t_filter();
    logic [7:0] s [8];
    s = '{CH_STX, 8'h03, 8'h41, CH_LF, CH_STX, 8'h04, 8'h42, CH_LF};
    bus(1, A_NET, 32'h104);
    u_host.send(0, 8'h43, 0, PAR_NONE);
    for (int i = 0; i < 8; i++) u_host.send(1, s[i], 0, PAR_NONE);
    rxe(32'h143);
    rxe(32'h142);
    rxe(32'h10A);
    rd(A_RXDATA); chk(rdat[8], 0);
    rd(A_STATUS); chk(rdat[ST_IF485], 1);
  endtask
  task automatic t_tx();
    logic [7:0] c;
    int n;
    bus(1, A_TXDATA, 32'h5A);
    n = 0;
    while (t485 !== 1'b0 && n < 10) begin @(posedge pclk); n++; end
    chk(de_n, 0);
    repeat (DIV / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin repeat (DIV) @(posedge pclk); c[i] = t485; end
    chk(c, 8'h5A);
    chk(t232, 1);
    repeat (3 * DIV) @(posedge pclk);
  endtask
  task automatic t_lock();
    bus(1, A_CTRL, 1); rd(A_NET); chk(rdat, 32'h0);
    bus(1, A_FRAME, 1); rd(A_STATUS); chk(rdat[ST_CMDERR], 1);
    bus(1, A_CTRL, 0); rd(A_FRAME); chk(rdat, 32'h0);
    bus(1, A_STATUS, 32'h10);
  endtask
  task automatic t_out();
    wrs(A_PORTWR, 32'h0005_00FF); chk(dout[47:40], 8'hFF);
    wrs(A_PORTWR, 32'h0006_0011); chk(dout[31:0], 32'h0);
    wrs(A_PORTWR, 32'h0000_0100); chk(dout[47:40], 8'hFF);
    wrs(A_POLWR, 32'h0005_000F); chk(dout[47:40], 8'hF0);
    wrs(A_BITCMD, 32'h0005_0007); chk(dout[47:40], 8'h70);
    wrs(A_BITCMD, 32'h0005_0107); chk(dout[47:40], 8'hF0);
    wrs(A_BITCMD, 32'h0005_0008); chk(dout[47:40], 8'hF0);
    wrs(A_STROBE, 2); chk(strobe, 0);
    wrs(A_STROBE, 1); chk(strobe, 1);
  endtask
  task automatic t_id_nv();
    int n;
    bus(1, A_IDIDX, 71); bus(1, A_IDDATA, 32'h78); bus(1, A_IDDATA, 32'h79);
    rd(A_STATUS); chk(rdat[ST_IDTRUNC], 1);
    bus(1, A_IDIDX, 71); rd(A_IDDATA); chk(rdat, 32'h78);
    @(posedge pclk);
    nlv <= 1'b1; nla <= NV_CFG_ADDR; nld <= 32'h0070_0010;
    @(posedge pclk);
    nlv <= 1'b0;
    rd(A_NET); chk(rdat, 32'h7);
    bus(1, A_CTRL, 2);
    n = 0;
    repeat (100) begin
      @(posedge pclk);
      if (nwv === 1'b1) n++;
      if (nwv === 1'b1 && nwa === NV_CFG_ADDR) chk(nwd[23:20], 4'h7);
    end
    chk(32'(n), 32'd73);
    bus(1, A_DIV, 32'h1B2); rd(A_DIV); chk(rdat, 32'h1B2);
    bus(1, A_DIV, 32'h1B1); rd(A_DIV); chk(rdat, 32'h1B2);
  endtask
  // four in the fifo, one pending, the sixth overruns
  task automatic t_fifo();
    for (int i = 0; i < 6; i++) u_host.send(0, 8'h30 + 8'(i), 0, PAR_NONE);
    repeat (8) @(posedge pclk);
    rd(A_STATUS); chk(rdat[ST_OVR], 1);
    for (int i = 0; i < 5; i++) begin rd(A_RXDATA); chk(rdat, 32'h130 + i); end
    rd(A_RXDATA); chk(rdat[8], 0);
    bus(1, A_STATUS, 32'h8);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; nlv = 0; nla = 0; nld = 0;
    fail_count = 0; total_checks = 0; presetn = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset(); t_frame(); t_filter(); t_tx(); t_lock(); t_out(); t_fifo(); t_id_nv();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    tally_and_finish();
  end
endmodule
